// ==== core/pisl_top.sv ====
// event status latch with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "pisl_regs.svh"
module pisl_top
	import pisl_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata_ff,
	output logic                   hreadyout_ff,
	output logic                   hresp_ff,
	input  wire logic [1:0]        cu_speed,
	input  wire logic              cu_duplex,
	input  wire logic              cu_link,
	input  wire logic              cu_mdix,
	input  wire logic              cu_polarity,
	input  wire logic              cu_sleep,
	input  wire logic              cu_dte_power,
	input  wire logic              cu_an_err,
	input  wire logic              cu_page_rx,
	input  wire logic              cu_an_done,
	input  wire logic              cu_sym_err,
	input  wire logic              cu_false_car,
	input  wire logic              cu_fifo_err,
	input  wire logic              cu_downshift,
	input  wire logic              cu_jabber,
	input  wire logic [1:0]        fi_speed,
	input  wire logic              fi_duplex,
	input  wire logic              fi_link,
	input  wire logic              fi_energy,
	input  wire logic              fi_page_rx,
	input  wire logic              fi_an_done,
	input  wire logic              fi_sym_err,
	input  wire logic              fi_false_car,
	input  wire logic              fi_fifo_err,
	output logic                   irq_ff
);

	// ****************************************
	// elaboration check
	// ****************************************
	generate
		if (ADDR_W < 8 || ADDR_W > 32)
		begin : g_bad_addr
			$error("pisl_top: ADDR_W must be 8 to 32");
		end
	endgenerate

	// ****************************************
	// declarations
	// ****************************************
	logic [5:0]  a_idx;
	logic        a_go;
	logic        a_rd;
	logic        wr_pend_ff;
	logic [5:0]  wr_idx_ff;
	logic        wr_go;
	logic        soft_rst;
	pisl_word_t  cu_st_ff;
	pisl_word_t  fi_st_ff;
	pisl_word_t  nxt_cu_st;
	pisl_word_t  nxt_fi_st;
	pisl_word_t  cu_en_ff;
	pisl_word_t  fi_en_ff;
	pisl_word_t  nxt_cu_en;
	pisl_word_t  nxt_fi_en;
	pisl_page_t  page_ff;
	pisl_page_t  nxt_page;
	logic [3:0]  mode_ff;
	logic [3:0]  nxt_mode;
	pisl_word_t  cu_set;
	pisl_word_t  fi_set;
	logic        rd_clr_cu;
	logic        rd_clr_fi;
	logic        mode_ok;
	logic [7:0]  cu_chg;
	logic [4:0]  fi_chg;
	logic [31:0] nxt_rdata;

	// ****************************************
	// address decode
	// ****************************************
	function automatic logic hit(input logic [5:0] idx, input logic [5:0] reg_idx);
		hit = (idx == reg_idx);
	endfunction

	assign a_idx = haddr[7:2];
	assign a_go = hsel & hready & htrans[1];
	assign a_rd = a_go & ~hwrite;
	assign wr_go = wr_pend_ff;
	assign soft_rst = wr_go && hit(wr_idx_ff, `PISL_IDX_CTRL) && hwdata[`PISL_CTRL_SRST];

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff <= 6'h00;
		end
		else if (hready)
		begin
			wr_pend_ff <= a_go & hwrite;
			wr_idx_ff <= a_idx;
		end
	end

	// ****************************************
	// change detectors
	// ****************************************
	pisl_chg #(
		.W (8)
	) u_cu_chg (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clr     (soft_rst),
		.lvl     ({cu_dte_power, cu_sleep, cu_polarity, cu_mdix,
		             cu_link, cu_duplex, cu_speed}),
		.chg     (cu_chg)
	);

	pisl_chg #(
		.W (5)
	) u_fi_chg (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clr     (soft_rst),
		.lvl     ({fi_energy, fi_link, fi_duplex, fi_speed}),
		.chg     (fi_chg)
	);

	// ****************************************
	// event words
	// ****************************************
	assign mode_ok = (mode_ff == `PISL_MODE_A) || (mode_ff == `PISL_MODE_B) ||
	                 (mode_ff == `PISL_MODE_C);

	always_comb
	begin
		cu_set = '0;
		cu_set[`PISL_B_ANERR] = cu_an_err;
		cu_set[`PISL_B_SPEED] = cu_chg[0] | cu_chg[1];
		cu_set[`PISL_B_DUPLEX] = cu_chg[2];
		cu_set[`PISL_B_PAGE] = cu_page_rx;
		cu_set[`PISL_B_ANDONE] = cu_an_done;
		cu_set[`PISL_B_LINK] = cu_chg[3];
		cu_set[`PISL_B_SYMERR] = cu_sym_err;
		cu_set[`PISL_B_FIFO] = cu_fifo_err;
		cu_set[`PISL_B_FCAR] = cu_false_car & (cu_speed != `PISL_SPEED_1000);
		cu_set[`PISL_B_MDIX] = cu_chg[4];
		cu_set[`PISL_B_DSHIFT] = cu_downshift;
		cu_set[`PISL_B_ENERGY] = cu_chg[6];
		cu_set[`PISL_B_DTE] = cu_chg[7];
		cu_set[`PISL_B_POL] = cu_chg[5];
		cu_set[`PISL_B_JABBER] = cu_jabber;
	end

	always_comb
	begin
		fi_set = '0;
		fi_set[`PISL_B_SPEED] = fi_chg[0] | fi_chg[1];
		fi_set[`PISL_B_DUPLEX] = fi_chg[2];
		fi_set[`PISL_B_PAGE] = fi_page_rx;
		fi_set[`PISL_B_ANDONE] = fi_an_done;
		fi_set[`PISL_B_LINK] = fi_chg[3];
		fi_set[`PISL_B_SYMERR] = fi_sym_err;
		fi_set[`PISL_B_FCAR] = fi_false_car;
		fi_set[`PISL_B_FIFO] = fi_fifo_err;
		fi_set[`PISL_B_ENERGY] = fi_chg[4] & mode_ok;
	end

	// ****************************************
	// latched status, set wins over read clear
	// ****************************************
	assign rd_clr_cu = a_rd && hit(a_idx, `PISL_IDX_STATUS) && (nxt_page == PISL_PAGE_COPPER);
	assign rd_clr_fi = a_rd && hit(a_idx, `PISL_IDX_STATUS) && (nxt_page == PISL_PAGE_FIBER);

	always_comb
	begin
		nxt_cu_st = cu_st_ff;
		nxt_fi_st = fi_st_ff;
		if (rd_clr_cu)
			nxt_cu_st = '0;
		if (rd_clr_fi)
			nxt_fi_st = '0;
		nxt_cu_st = nxt_cu_st | cu_set;
		nxt_fi_st = nxt_fi_st | fi_set;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst || soft_rst)
		begin
			cu_st_ff <= `PISL_STATUS_RST;
			fi_st_ff <= `PISL_STATUS_RST;
		end
		else
		begin
			cu_st_ff <= nxt_cu_st & `PISL_CU_MASK;
			fi_st_ff <= nxt_fi_st & `PISL_FI_MASK;
		end
	end

	// ****************************************
	// writable registers, kept over soft reset
	// ****************************************
	always_comb
	begin
		nxt_cu_en = cu_en_ff;
		nxt_fi_en = fi_en_ff;
		nxt_page = page_ff;
		nxt_mode = mode_ff;
		if (wr_go && hit(wr_idx_ff, `PISL_IDX_ENABLE))
		begin
			if (page_ff == PISL_PAGE_COPPER)
				nxt_cu_en = hwdata[15:0] & `PISL_CU_MASK;
			else
				nxt_fi_en = hwdata[15:0] & `PISL_FI_MASK;
		end
		if (wr_go && hit(wr_idx_ff, `PISL_IDX_PAGE))
			nxt_page = pisl_page_t'(hwdata[0]);
		if (wr_go && hit(wr_idx_ff, `PISL_IDX_MODE))
			nxt_mode = hwdata[3:0];
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			cu_en_ff <= `PISL_ENABLE_RST;
			fi_en_ff <= `PISL_ENABLE_RST;
			page_ff <= PISL_PAGE_COPPER;
			mode_ff <= `PISL_MODE_RST;
		end
		else
		begin
			cu_en_ff <= nxt_cu_en;
			fi_en_ff <= nxt_fi_en;
			page_ff <= nxt_page;
			mode_ff <= nxt_mode;
		end
	end

	// ****************************************
	// read mux, forwards a pending write
	// ****************************************
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		case (a_idx)
			`PISL_IDX_STATUS:
				nxt_rdata[15:0] = (nxt_page == PISL_PAGE_COPPER) ? cu_st_ff : fi_st_ff;
			`PISL_IDX_ENABLE:
				nxt_rdata[15:0] = (nxt_page == PISL_PAGE_COPPER) ? nxt_cu_en : nxt_fi_en;
			`PISL_IDX_PAGE:
				nxt_rdata[0] = nxt_page;
			`PISL_IDX_MODE:
				nxt_rdata[3:0] = nxt_mode;
			default:
				nxt_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			hrdata_ff <= 32'h0000_0000;
		else if (a_rd)
			hrdata_ff <= nxt_rdata;
	end

	always_ff @(posedge sys_clk)
	begin
		hreadyout_ff <= 1'b1;
		hresp_ff <= 1'b0;
	end

	// ****************************************
	// interrupt output
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			irq_ff <= 1'b0;
		else
			irq_ff <= |((cu_st_ff & cu_en_ff) | (fi_st_ff & fi_en_ff));
	end

	// ****************************************
	// assertions
	// ****************************************
	sequence s_cu_read;
		rd_clr_cu && !soft_rst;
	endsequence
	sequence s_quiet_cu;
		!rd_clr_cu && !soft_rst;
	endsequence
	property p_hold;
		@(posedge sys_clk) disable iff (rst)
		s_quiet_cu |=> ((cu_st_ff & $past(cu_st_ff)) == $past(cu_st_ff));
	endproperty
	a_hold: assert property (p_hold) else $error("status bit dropped without read");
	property p_rdclr;
		@(posedge sys_clk) disable iff (rst)
		s_cu_read |=> (cu_st_ff == ($past(cu_set) & `PISL_CU_MASK));
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("read did not clear status");
	property p_anerr;
		@(posedge sys_clk) disable iff (rst)
		(cu_an_err && !soft_rst) |=> cu_st_ff[`PISL_B_ANERR];
	endproperty
	a_anerr: assert property (p_anerr) else $error("negotiation error not latched");
	property p_speed;
		@(posedge sys_clk) disable iff (rst)
		((cu_chg[0] || cu_chg[1]) && !soft_rst) |=> cu_st_ff[`PISL_B_SPEED];
	endproperty
	a_speed: assert property (p_speed) else $error("speed change not latched");
	property p_link;
		@(posedge sys_clk) disable iff (rst)
		(cu_chg[3] && !soft_rst) |=> cu_st_ff[`PISL_B_LINK];
	endproperty
	a_link: assert property (p_link) else $error("link change not latched");
	property p_fc_gig;
		@(posedge sys_clk) disable iff (rst)
		(!cu_st_ff[`PISL_B_FCAR] && cu_speed == `PISL_SPEED_1000) |=> !cu_st_ff[`PISL_B_FCAR];
	endproperty
	a_fc_gig: assert property (p_fc_gig) else $error("false carrier set at gigabit");
	property p_fi_sym;
		@(posedge sys_clk) disable iff (rst)
		(fi_sym_err && !soft_rst) |=> fi_st_ff[`PISL_B_SYMERR];
	endproperty
	a_fi_sym: assert property (p_fi_sym) else $error("fiber symbol error not latched");
	property p_energy;
		@(posedge sys_clk) disable iff (rst)
		(!fi_st_ff[`PISL_B_ENERGY] && !mode_ok) |=> !fi_st_ff[`PISL_B_ENERGY];
	endproperty
	a_energy: assert property (p_energy) else $error("fiber energy set in wrong mode");
	property p_srst;
		@(posedge sys_clk) disable iff (rst)
		soft_rst |=> (cu_st_ff == 16'h0000) && (fi_st_ff == 16'h0000);
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset left status set");
	property p_irq;
		@(posedge sys_clk) disable iff (rst)
		((cu_st_ff & cu_en_ff) != 16'h0000) |=> irq_ff;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing for enabled bit");
	property p_enable;
		@(posedge sys_clk) disable iff (rst)
		(wr_go && hit(wr_idx_ff, `PISL_IDX_ENABLE) && page_ff == PISL_PAGE_COPPER)
		|=> (cu_en_ff == ($past(hwdata[15:0]) & `PISL_CU_MASK));
	endproperty
	a_enable: assert property (p_enable) else $error("enable write lost");

endmodule
`default_nettype wire

// ==== core/pisl_regs.svh ====
// register map, field positions and reset values of the event status latch
//
// Behaviour
// - copper bit 15 latches negotiation errors
// - bit 14 latches on speed change
// - bit 13 latches on duplex change
// - bit 12 latches on page received
// - bit 11 latches on negotiation done
// - bit 10 latches on link change
// - bit 9 symbol error, bit 7 fifo
// - copper false carrier never at gigabit
// - copper bit 6 latches on crossover change
// - copper bit 5 latches on downshift
// - copper bit 4 latches on sleep toggle
// - copper bit 2 latches on power detect
// - copper bit 1 polarity, bit 0 jabber
// - fiber bits 14..7 mirror those events
// - fiber bit 4 energy, only certain modes
// - each event has its own enable bit
`ifndef PISL_REGS_SVH
`define PISL_REGS_SVH

// ****************************************
// register indices, byte address is four times
// ****************************************
`define PISL_IDX_CTRL     6'h00
`define PISL_IDX_ENABLE   6'h12
`define PISL_IDX_STATUS   6'h13
`define PISL_IDX_PAGE     6'h16
`define PISL_IDX_MODE     6'h1b

// ****************************************
// field positions
// ****************************************
`define PISL_CTRL_SRST    15
`define PISL_B_ANERR      15
`define PISL_B_SPEED      14
`define PISL_B_DUPLEX     13
`define PISL_B_PAGE       12
`define PISL_B_ANDONE     11
`define PISL_B_LINK       10
`define PISL_B_SYMERR     9
`define PISL_B_FCAR       8
`define PISL_B_FIFO       7
`define PISL_B_MDIX       6
`define PISL_B_DSHIFT     5
`define PISL_B_ENERGY     4
`define PISL_B_DTE        2
`define PISL_B_POL        1
`define PISL_B_JABBER     0

// ****************************************
// implemented bits and reset values
// ****************************************
`define PISL_CU_MASK      16'hfff7
`define PISL_FI_MASK      16'h7f90
`define PISL_STATUS_RST   16'h0000
`define PISL_ENABLE_RST   16'h0000
`define PISL_MODE_RST     4'h0
`define PISL_SPEED_1000   2'h2
`define PISL_MODE_A       4'h0
`define PISL_MODE_B       4'h6
`define PISL_MODE_C       4'he

`endif

// ==== core/pisl_pkg.sv ====
// types of the event status latch
package pisl_pkg;

	typedef logic [15:0] pisl_word_t;

	typedef enum logic
	{
		PISL_PAGE_COPPER,
		PISL_PAGE_FIBER
	} pisl_page_t;

endpackage

// ==== core/pisl_chg.sv ====
// per-bit change detector for level status inputs
`timescale 1ns/1ps
`default_nettype none
module pisl_chg
	import pisl_pkg::*;
#(
	parameter int W = 4
)
(
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic         clr,
	input  wire logic [W-1:0] lvl,
	output logic      [W-1:0] chg
);

	logic [W-1:0] prev_ff;
	logic         armed_ff;

	generate
		if (W < 1)
		begin : g_bad_w
			$error("pisl_chg: W must be at least 1");
		end
	endgenerate

	// ****************************************
	// first sample after reset only arms
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst || clr)
			armed_ff <= 1'b0;
		else
			armed_ff <= 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			prev_ff <= '0;
		else
			prev_ff <= lvl;
	end

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			assign chg[i] = armed_ff & (lvl[i] ^ prev_ff[i]);
		end
	endgenerate

endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench of the event status latch
`timescale 1ns/1ps
`default_nettype none
`include "pisl_regs.svh"
module tb_top
	import pisl_pkg::*;
;
	// ****************
	// signals and model
	// ****************
	logic        sys_clk;
	logic        rst;
	logic        hsel;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata_ff;
	logic        hreadyout_ff;
	logic        hresp_ff;
	logic        irq_ff;
	logic [1:0]  cu_speed;
	logic [1:0]  fi_speed;
	logic [7:0]  cu_ev;
	logic [5:0]  cu_lv;
	logic [4:0]  fi_ev;
	logic [2:0]  fi_lv;
	pisl_word_t  m_cu;
	pisl_word_t  m_fi;
	pisl_word_t  m_en_cu;
	pisl_word_t  m_en_fi;
	logic [3:0]  m_mode;
	logic [31:0] rd;
	int          fail_count;
	int          compares;
	int          cu_ev_bit[8] = '{15, 12, 11, 9, 8, 7, 5, 0};
	int          cu_lv_bit[6] = '{13, 10, 6, 1, 4, 2};
	int          fi_ev_bit[5] = '{12, 11, 9, 8, 7};
	int          fi_lv_bit[3] = '{13, 10, 4};
	logic [3:0]  modes[4] = '{4'h0, 4'h6, 4'he, 4'h9};

	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	pisl_top #(.ADDR_W(8)) dut
	(
		.sys_clk      (sys_clk),
		.rst          (rst),
		.hsel         (hsel),
		.haddr        (haddr),
		.htrans       (htrans),
		.hwrite       (hwrite),
		.hsize        (hsize),
		.hwdata       (hwdata),
		.hready       (hreadyout_ff),
		.hrdata_ff    (hrdata_ff),
		.hreadyout_ff (hreadyout_ff),
		.hresp_ff     (hresp_ff),
		.cu_speed     (cu_speed),
		.cu_duplex    (cu_lv[0]),
		.cu_link      (cu_lv[1]),
		.cu_mdix      (cu_lv[2]),
		.cu_polarity  (cu_lv[3]),
		.cu_sleep     (cu_lv[4]),
		.cu_dte_power (cu_lv[5]),
		.cu_an_err    (cu_ev[0]),
		.cu_page_rx   (cu_ev[1]),
		.cu_an_done   (cu_ev[2]),
		.cu_sym_err   (cu_ev[3]),
		.cu_false_car (cu_ev[4]),
		.cu_fifo_err  (cu_ev[5]),
		.cu_downshift (cu_ev[6]),
		.cu_jabber    (cu_ev[7]),
		.fi_speed     (fi_speed),
		.fi_duplex    (fi_lv[0]),
		.fi_link      (fi_lv[1]),
		.fi_energy    (fi_lv[2]),
		.fi_page_rx   (fi_ev[0]),
		.fi_an_done   (fi_ev[1]),
		.fi_sym_err   (fi_ev[2]),
		.fi_false_car (fi_ev[3]),
		.fi_fifo_err  (fi_ev[4]),
		.irq_ff       (irq_ff)
	);

	// ****************
	// tasks
	// ****************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (hreadyout_ff !== 1'b1 && n < 16);
		if (hreadyout_ff !== 1'b1)
		begin
			fail_count++;
			test_done();
		end
	endtask

	task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {idx, 2'b00};
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata_ff;
		chk({31'h0, hresp_ff}, 32'h0);
	endtask

	task automatic chk_irq();
		chk({31'h0, irq_ff}, {31'h0, (|(m_cu & m_en_cu)) | (|(m_fi & m_en_fi))});
	endtask

	task automatic setup(input int it);
		logic [31:0] r0;
		logic [31:0] r1;
		r0 = $urandom & {16'h0, `PISL_CU_MASK};
		r1 = $urandom & {16'h0, `PISL_FI_MASK};
		m_mode = (it % 4 == 3) ? 4'($urandom) : modes[it % 4];
		bus(1'b1, `PISL_IDX_PAGE, 32'h0);
		bus(1'b1, `PISL_IDX_ENABLE, r0);
		bus(1'b0, `PISL_IDX_ENABLE, 32'h0);
		m_en_cu = r0[15:0] & `PISL_CU_MASK;
		chk(rd, {16'h0, m_en_cu});
		bus(1'b1, `PISL_IDX_PAGE, 32'h1);
		bus(1'b1, `PISL_IDX_ENABLE, r1);
		bus(1'b0, `PISL_IDX_ENABLE, 32'h0);
		m_en_fi = r1[15:0] & `PISL_FI_MASK;
		chk(rd, {16'h0, m_en_fi});
		bus(1'b1, `PISL_IDX_MODE, {28'h0, m_mode});
	endtask

	task automatic stim();
		logic [7:0] e;
		logic [5:0] l;
		logic [4:0] f;
		logic [2:0] g;
		logic [1:0] s;
		logic [1:0] t;
		e = 8'($urandom);
		l = 6'($urandom);
		f = 5'($urandom);
		g = 3'($urandom);
		s = 2'($urandom);
		t = 2'($urandom);
		for (int i = 0; i < 8; i++)
			if (e[i] && !(i == 4 && s == `PISL_SPEED_1000))
				m_cu[cu_ev_bit[i]] = 1'b1;
		for (int i = 0; i < 6; i++)
			if (l[i] != cu_lv[i])
				m_cu[cu_lv_bit[i]] = 1'b1;
		for (int i = 0; i < 5; i++)
			if (f[i])
				m_fi[fi_ev_bit[i]] = 1'b1;
		for (int i = 0; i < 3; i++)
			if (g[i] != fi_lv[i] && (i != 2 || m_mode inside {4'h0, 4'h6, 4'he}))
				m_fi[fi_lv_bit[i]] = 1'b1;
		if (s != cu_speed)
			m_cu[14] = 1'b1;
		if (t != fi_speed)
			m_fi[14] = 1'b1;
		cu_ev <= e;
		cu_lv <= l;
		fi_ev <= f;
		fi_lv <= g;
		cu_speed <= s;
		fi_speed <= t;
		@(posedge sys_clk);
		cu_ev <= 8'h0;
		fi_ev <= 5'h0;
	endtask

	// ****************
	// main sequence
	// ****************
	initial
	begin
		{rst, hsel, haddr, htrans, hwrite, hwdata} = {1'b1, 44'h0};
		hsize = 3'b010;
		{cu_speed, fi_speed, cu_ev, cu_lv, fi_ev, fi_lv} = 26'h0;
		{m_cu, m_fi, m_en_cu, m_en_fi} = 64'h0;
		fail_count = 0;
		compares = 0;
		void'($urandom(53));
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		bus(1'b0, `PISL_IDX_STATUS, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, 6'h3f, $urandom);
		bus(1'b0, 6'h3f, 32'h0);
		chk(rd, 32'h0);
		for (int it = 0; it < 40; it++)
		begin
			setup(it);
			stim();
			repeat (3 + (it % 3) * 10) @(posedge sys_clk);
			chk_irq();
			if (it % 10 == 5)
			begin
				bus(1'b1, `PISL_IDX_CTRL, 32'h8000);
				{m_cu, m_fi} = 32'h0;
				bus(1'b0, `PISL_IDX_ENABLE, 32'h0);
				chk(rd, {16'h0, m_en_fi});
			end
			if (it == 32)
			begin
				rst <= 1'b1;
				repeat (10) @(posedge sys_clk);
				rst <= 1'b0;
				@(posedge sys_clk);
				{m_cu, m_fi, m_en_cu, m_en_fi} = 64'h0;
				bus(1'b1, `PISL_IDX_PAGE, 32'h1);
			end
			bus(1'b0, `PISL_IDX_STATUS, 32'h0);
			chk(rd, {16'h0, m_fi});
			m_fi = 16'h0;
			bus(1'b1, `PISL_IDX_PAGE, 32'h0);
			bus(1'b0, `PISL_IDX_STATUS, 32'h0);
			chk(rd & 32'hff00, {16'h0, m_cu & 16'hff00});
			chk(rd & 32'hffff00ff, {16'h0, m_cu & 16'h00ff});
			m_cu = 16'h0;
			repeat (2) @(posedge sys_clk);
			chk_irq();
		end
		test_done();
	end
endmodule
`default_nettype wire
